/* File: hw/mpm_defs.vh */
/*
 * Constants of the motor protection fault monitor: register offsets,
 * field positions, reset values, event codes and timing figures.
 * Assumes inclusion by bare name from the design and checker files of this block.
 */
`ifndef MPM_DEFS_VH
`define MPM_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define MPM_OFS_CTRL       8'h00
`define MPM_OFS_ALARM_SEL  8'h04
`define MPM_OFS_RATED_I    8'h08
`define MPM_OFS_RATED_P    8'h0C
`define MPM_OFS_STARTER_I  8'h10
`define MPM_OFS_IMB        8'h14
`define MPM_OFS_UTQ        8'h18
`define MPM_OFS_OTQ        8'h1C
`define MPM_OFS_UPW        8'h20
`define MPM_OFS_OPW        8'h24
`define MPM_OFS_BYP_TIME   8'h28
`define MPM_OFS_STATUS     8'h2C
`define MPM_OFS_MASK       8'h30
`define MPM_OFS_LIVE       8'h34
`define MPM_OFS_LAST_EVENT 8'h38

// ----------------------------------------------------------------------
// field layout of the limit registers: threshold low, time high
// ----------------------------------------------------------------------
`define MPM_THR_LSB 0
`define MPM_THR_MSB 7
`define MPM_TIME_LSB 16
`define MPM_TIME_MSB 31
`define MPM_CTRL_BYP_UC_EN 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MPM_RST_CTRL      1'h1
`define MPM_RST_RATED     16'h0064
`define MPM_RST_LIMIT     32'h000A_0014
`define MPM_RST_BYP_TIME  16'h0064
`define MPM_RST_ALARM_SEL 10'h000
`define MPM_RST_MASK      10'h000

// ----------------------------------------------------------------------
// event bit positions and their event codes
// ----------------------------------------------------------------------
`define MPM_NEV           10
`define MPM_EV_IMB        0
`define MPM_EV_FREQ       1
`define MPM_EV_BYP_UC     2
`define MPM_EV_BYP_STUCK  3
`define MPM_EV_UTQ        4
`define MPM_EV_OTQ        5
`define MPM_EV_UPW        6
`define MPM_EV_OPW        7
`define MPM_EV_BAY1       8
`define MPM_EV_BAY2       9
`define MPM_CODE_BASE     8'h4A
`define MPM_ALARM_CAPABLE 10'h0F1

// ----------------------------------------------------------------------
// arithmetic and timing figures
// ----------------------------------------------------------------------
`define MPM_PCT_SCALE     16'h0064
`define MPM_UC_DIV        16'h000A
`define MPM_F50_LO        16'h01C2
`define MPM_F50_HI        16'h0226
`define MPM_F60_LO        16'h021C
`define MPM_F60_HI        16'h0294
`define MPM_CLK_PERIOD_NS 100
`define MPM_TICK_NS       1000000
`define MPM_FREQ_TIME_MS  16'h01F4

`endif

/* File: hw/mpm_monitor.v */
/*
 * Motor protection fault monitor: APB register file, threshold
 * comparators, persistence timers, bypass contactor checks, accessory
 * compatibility checks, sticky event status and interrupt.
 * Assumes measurement inputs synchronous to clk and held stable between
 * updates; ramp_end and bypass_open_cmd are one-cycle pulses.
 */
// The APB slave port and the register offsets were decided locally.
// Function
// - Flag imbalance when the widest phase current spread, in percent of rated motor current, passes the threshold longer than the imbalance time.
// - While running, fault when line frequency sits outside both ten percent bands around 50 Hz and 60 Hz longer than half a second.
// - At ramp end, before bypass closure, fault when motor current is below a tenth of the starter rated current.
// - Skip the bypass undercurrent check when its enable is zero.
// - Fault when a commanded bypass opening is not confirmed.
// - Flag undertorque when 100 minus torque percent passes the threshold longer than the undertorque time.
// - Flag overtorque when torque percent minus 100 passes the threshold longer than the overtorque time.
// - Flag underpower when the power shortfall in percent of rated power passes the threshold longer than its time.
// - Flag overpower when the power excess in percent of rated power passes the threshold longer than its time.
// - Raise a separate incompatibility fault for each accessory bay.
`timescale 1ns/10ps
`include "mpm_defs.vh"

module mpm_monitor #(
  parameter TICK_CYCLES = `MPM_TICK_NS / `MPM_CLK_PERIOD_NS,
  parameter DW = 16
) (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [DW-1:0] phase_a_current_reading,
  input wire [DW-1:0] phase_b_current_reading,
  input wire [DW-1:0] phase_c_current_reading,
  input wire [DW-1:0] line_freq_reading,
  input wire [DW-1:0] motor_torque_reading,
  input wire [DW-1:0] motor_power_reading,
  input wire motor_running,
  input wire ramp_end,
  input wire bypass_open_cmd,
  input wire bypass_closed_fb,
  input wire accessory_bay_first_present,
  input wire accessory_bay_first_compat,
  input wire accessory_bay_second_present,
  input wire accessory_bay_second_compat,
  output wire irq,
  output wire fault_out,
  output wire alarm_out,
  output wire [7:0] event_code,
  output wire event_valid
);

  localparam NEV = `MPM_NEV;

  // ----------------------------------------------------------------------
  // register file state
  // ----------------------------------------------------------------------
  reg byp_uc_enable_reg;
  reg [NEV-1:0] alarm_sel_reg;
  reg [DW-1:0] rated_motor_current_reg;
  reg [DW-1:0] rated_motor_power_reg;
  reg [DW-1:0] starter_rated_current_reg;
  reg [31:0] imb_limit_reg;
  reg [31:0] utq_limit_reg;
  reg [31:0] otq_limit_reg;
  reg [31:0] upw_limit_reg;
  reg [31:0] opw_limit_reg;
  reg [15:0] byp_time_reg;
  reg [NEV-1:0] status_reg;
  reg [NEV-1:0] mask_reg;
  reg [7:0] last_event_reg;
  reg event_valid_reg;
  reg [31:0] rdata_reg;
  reg err_reg;
  reg [31:0] rdata_next;
  reg err_next;

  // ----------------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------------
  reg [23:0] pre_reg;
  reg tick_reg;
  wire pre_wrap = (pre_reg == TICK_CYCLES[23:0] - 24'h000001);

  // ----------------------------------------------------------------------
  // bypass supervision state
  // ----------------------------------------------------------------------
  localparam BS_IDLE = 2'b01;
  localparam BS_WAIT = 2'b10;
  reg [1:0] bs_reg;
  reg [1:0] bs_next;
  reg [15:0] bs_cnt_reg;
  reg [15:0] bs_cnt_next;
  reg byp_uc_live_reg;
  reg byp_stuck_live_reg;

  wire [NEV-1:0] live;
  reg [NEV-1:0] live_d_reg;
  wire [NEV-1:0] ev;
  wire [7:0] live_pers;

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, read data captured in the setup cycle
  // ----------------------------------------------------------------------
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = err_reg && psel && penable;

  always @* begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr)
      `MPM_OFS_CTRL: rdata_next = {31'h0000_0000, byp_uc_enable_reg};
      `MPM_OFS_ALARM_SEL: rdata_next = {22'h00_0000, alarm_sel_reg};
      `MPM_OFS_RATED_I: rdata_next = {16'h0000, rated_motor_current_reg};
      `MPM_OFS_RATED_P: rdata_next = {16'h0000, rated_motor_power_reg};
      `MPM_OFS_STARTER_I: rdata_next = {16'h0000, starter_rated_current_reg};
      `MPM_OFS_IMB: rdata_next = imb_limit_reg;
      `MPM_OFS_UTQ: rdata_next = utq_limit_reg;
      `MPM_OFS_OTQ: rdata_next = otq_limit_reg;
      `MPM_OFS_UPW: rdata_next = upw_limit_reg;
      `MPM_OFS_OPW: rdata_next = opw_limit_reg;
      `MPM_OFS_BYP_TIME: rdata_next = {16'h0000, byp_time_reg};
      `MPM_OFS_STATUS: rdata_next = {22'h00_0000, status_reg};
      `MPM_OFS_MASK: rdata_next = {22'h00_0000, mask_reg};
      `MPM_OFS_LIVE: rdata_next = {22'h00_0000, live};
      `MPM_OFS_LAST_EVENT: rdata_next = {24'h00_0000, last_event_reg};
      default: err_next = 1'b1;
    endcase
  end

  // read capture; the master holds paddr through the access phase
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      err_reg <= err_next;
    end
  end

  // configuration writes, taken at the access edge only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byp_uc_enable_reg <= `MPM_RST_CTRL;
      alarm_sel_reg <= `MPM_RST_ALARM_SEL;
      rated_motor_current_reg <= `MPM_RST_RATED;
      rated_motor_power_reg <= `MPM_RST_RATED;
      starter_rated_current_reg <= `MPM_RST_RATED;
      imb_limit_reg <= `MPM_RST_LIMIT;
      utq_limit_reg <= `MPM_RST_LIMIT;
      otq_limit_reg <= `MPM_RST_LIMIT;
      upw_limit_reg <= `MPM_RST_LIMIT;
      opw_limit_reg <= `MPM_RST_LIMIT;
      byp_time_reg <= `MPM_RST_BYP_TIME;
      mask_reg <= `MPM_RST_MASK;
    end else if (wr_en) begin
      case (paddr)
        `MPM_OFS_CTRL: byp_uc_enable_reg <= pwdata[`MPM_CTRL_BYP_UC_EN];
        `MPM_OFS_ALARM_SEL: alarm_sel_reg <= pwdata[NEV-1:0];
        `MPM_OFS_RATED_I: rated_motor_current_reg <= pwdata[DW-1:0];
        `MPM_OFS_RATED_P: rated_motor_power_reg <= pwdata[DW-1:0];
        `MPM_OFS_STARTER_I: starter_rated_current_reg <= pwdata[DW-1:0];
        `MPM_OFS_IMB: imb_limit_reg <= pwdata;
        `MPM_OFS_UTQ: utq_limit_reg <= pwdata;
        `MPM_OFS_OTQ: otq_limit_reg <= pwdata;
        `MPM_OFS_UPW: upw_limit_reg <= pwdata;
        `MPM_OFS_OPW: opw_limit_reg <= pwdata;
        `MPM_OFS_BYP_TIME: byp_time_reg <= pwdata[15:0];
        `MPM_OFS_MASK: mask_reg <= pwdata[NEV-1:0];
        default: byp_time_reg <= byp_time_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // prescaler: one tick per millisecond at the nominal clock
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 24'h000000;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_wrap ? 24'h000000 : pre_reg + 24'h000001;
      tick_reg <= pre_wrap;
    end
  end

  // ----------------------------------------------------------------------
  // current imbalance: widest spread of the three phases
  // ----------------------------------------------------------------------
  wire [DW-1:0] ia = phase_a_current_reading;
  wire [DW-1:0] ib = phase_b_current_reading;
  wire [DW-1:0] ic = phase_c_current_reading;
  wire [DW-1:0] imax_ab = (ia > ib) ? ia : ib;
  wire [DW-1:0] imin_ab = (ia > ib) ? ib : ia;
  wire [DW-1:0] i_max = (imax_ab > ic) ? imax_ab : ic;
  wire [DW-1:0] i_min = (imin_ab < ic) ? imin_ab : ic;
  wire [DW-1:0] i_spread = i_max - i_min;
  // cross-multiplied so no divider is needed: d*100 > thr*rated
  wire [31:0] imb_lhs = {16'h0000, i_spread} * {16'h0000, `MPM_PCT_SCALE};
  wire [31:0] imb_rhs = {24'h00_0000, imb_limit_reg[`MPM_THR_MSB:`MPM_THR_LSB]}
                        * {16'h0000, rated_motor_current_reg};
  wire cond_imb = imb_lhs > imb_rhs;

  // ----------------------------------------------------------------------
  // line frequency bands, readings in tenths of a hertz
  // ----------------------------------------------------------------------
  wire f_in50 = (line_freq_reading >= `MPM_F50_LO) &&
                (line_freq_reading <= `MPM_F50_HI);
  wire f_in60 = (line_freq_reading >= `MPM_F60_LO) &&
                (line_freq_reading <= `MPM_F60_HI);
  wire cond_freq = motor_running && !f_in50 && !f_in60;

  // ----------------------------------------------------------------------
  // torque, reading already in percent of rated torque
  // ----------------------------------------------------------------------
  wire [DW-1:0] tq = motor_torque_reading;
  wire [DW-1:0] utq_pct = `MPM_PCT_SCALE - tq;
  wire [DW-1:0] otq_pct = tq - `MPM_PCT_SCALE;
  wire [DW-1:0] utq_thr = {8'h00, utq_limit_reg[`MPM_THR_MSB:`MPM_THR_LSB]};
  wire [DW-1:0] otq_thr = {8'h00, otq_limit_reg[`MPM_THR_MSB:`MPM_THR_LSB]};
  wire cond_utq = (tq < `MPM_PCT_SCALE) && (utq_pct > utq_thr);
  wire cond_otq = (tq > `MPM_PCT_SCALE) && (otq_pct > otq_thr);

  // ----------------------------------------------------------------------
  // power deviation in percent of rated power, cross-multiplied
  // ----------------------------------------------------------------------
  wire [DW-1:0] pw = motor_power_reading;
  wire [DW-1:0] prt = rated_motor_power_reg;
  wire [DW-1:0] p_short = prt - pw;
  wire [DW-1:0] p_excess = pw - prt;
  wire [31:0] upw_lhs = {16'h0000, p_short} * {16'h0000, `MPM_PCT_SCALE};
  wire [31:0] opw_lhs = {16'h0000, p_excess} * {16'h0000, `MPM_PCT_SCALE};
  wire [31:0] upw_rhs = {24'h00_0000, upw_limit_reg[`MPM_THR_MSB:`MPM_THR_LSB]}
                        * {16'h0000, prt};
  wire [31:0] opw_rhs = {24'h00_0000, opw_limit_reg[`MPM_THR_MSB:`MPM_THR_LSB]}
                        * {16'h0000, prt};
  wire cond_upw = (pw < prt) && (upw_lhs > upw_rhs);
  wire cond_opw = (pw > prt) && (opw_lhs > opw_rhs);

  // ----------------------------------------------------------------------
  // persistence timers, one per timed condition
  // ----------------------------------------------------------------------
  wire [5:0] p_cond = {cond_opw, cond_upw, cond_otq, cond_utq,
                       cond_freq, cond_imb};
  wire [95:0] p_limit = {opw_limit_reg[`MPM_TIME_MSB:`MPM_TIME_LSB],
                         upw_limit_reg[`MPM_TIME_MSB:`MPM_TIME_LSB],
                         otq_limit_reg[`MPM_TIME_MSB:`MPM_TIME_LSB],
                         utq_limit_reg[`MPM_TIME_MSB:`MPM_TIME_LSB],
                         `MPM_FREQ_TIME_MS,
                         imb_limit_reg[`MPM_TIME_MSB:`MPM_TIME_LSB]};
  wire [5:0] p_exp;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pers
      mpm_persist #(
        .CW(16)
      ) u_pers (
        .clk(clk),
        .resetn(resetn),
        .tick(tick_reg),
        .cond(p_cond[gi]),
        .limit(p_limit[gi*16 +: 16]),
        .expired(p_exp[gi])
      );
    end
  endgenerate

  assign live_pers = {p_exp[5:2], 2'b00, p_exp[1:0]};

  // ----------------------------------------------------------------------
  // bypass contactor supervision
  // ----------------------------------------------------------------------
  // ramp end only; current times ten, so a divider cannot round it away
  wire [31:0] uc_lhs = {16'h0000, i_max} * {16'h0000, `MPM_UC_DIV};
  wire [31:0] uc_rhs = {16'h0000, starter_rated_current_reg};
  wire byp_uc_hit = ramp_end && byp_uc_enable_reg &&
                    (uc_lhs < uc_rhs);

  always @* begin
    bs_next = bs_reg;
    bs_cnt_next = bs_cnt_reg;
    case (bs_reg)
      BS_IDLE: begin
        if (bypass_open_cmd) begin
          bs_next = BS_WAIT;
          bs_cnt_next = 16'h0000;
        end
      end
      BS_WAIT: begin
        if (!bypass_closed_fb) begin
          bs_next = BS_IDLE;
        end else if (tick_reg) begin
          bs_cnt_next = bs_cnt_reg + 16'h0001;
          if (bs_cnt_reg >= byp_time_reg) begin
            bs_next = BS_IDLE;
          end
        end
      end
      default: bs_next = BS_IDLE;
    endcase
  end

  // open never confirmed within the window: contacts stuck closed
  wire byp_stuck_hit = (bs_reg == BS_WAIT) && bypass_closed_fb &&
                       tick_reg && (bs_cnt_reg >= byp_time_reg);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bs_reg <= BS_IDLE;
      bs_cnt_reg <= 16'h0000;
      byp_uc_live_reg <= 1'b0;
      byp_stuck_live_reg <= 1'b0;
    end else begin
      bs_reg <= bs_next;
      bs_cnt_reg <= bs_cnt_next;
      // live flags hold until the next start or a fresh check
      if (byp_uc_hit) begin
        byp_uc_live_reg <= 1'b1;
      end else if (ramp_end) begin
        byp_uc_live_reg <= 1'b0;
      end
      if (byp_stuck_hit) begin
        byp_stuck_live_reg <= 1'b1;
      end else if (bypass_open_cmd) begin
        byp_stuck_live_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // live conditions and rising-edge events
  // ----------------------------------------------------------------------
  assign live[`MPM_EV_IMB] = live_pers[`MPM_EV_IMB];
  assign live[`MPM_EV_FREQ] = live_pers[`MPM_EV_FREQ];
  assign live[`MPM_EV_BYP_UC] = byp_uc_live_reg;
  assign live[`MPM_EV_BYP_STUCK] = byp_stuck_live_reg;
  assign live[`MPM_EV_OPW:`MPM_EV_UTQ] = live_pers[`MPM_EV_OPW:`MPM_EV_UTQ];
  assign live[`MPM_EV_BAY1] = accessory_bay_first_present &&
                              !accessory_bay_first_compat;
  assign live[`MPM_EV_BAY2] = accessory_bay_second_present &&
                              !accessory_bay_second_compat;

  assign ev = live & ~live_d_reg;

  // lowest bit wins when several conditions rise together
  reg [7:0] code_next;
  integer k;
  always @* begin
    code_next = last_event_reg;
    for (k = NEV - 1; k >= 0; k = k - 1) begin
      if (ev[k]) begin
        code_next = `MPM_CODE_BASE + k[7:0];
      end
    end
  end

  // sticky status: a new event beats a write-one-to-clear in that cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live_d_reg <= {NEV{1'b0}};
      status_reg <= {NEV{1'b0}};
      last_event_reg <= 8'h00;
      event_valid_reg <= 1'b0;
    end else begin
      live_d_reg <= live;
      if (wr_en && paddr == `MPM_OFS_STATUS) begin
        status_reg <= (status_reg & ~pwdata[NEV-1:0]) | ev;
      end else begin
        status_reg <= status_reg | ev;
      end
      last_event_reg <= code_next;
      event_valid_reg <= |ev;
    end
  end

  // ----------------------------------------------------------------------
  // outputs: alarms follow the live condition, faults stay latched
  // ----------------------------------------------------------------------
  wire [NEV-1:0] as_alarm = alarm_sel_reg & `MPM_ALARM_CAPABLE;
  assign fault_out = |(status_reg & ~as_alarm);
  assign alarm_out = |(live & as_alarm);
  assign irq = |(status_reg & mask_reg);
  assign event_code = last_event_reg;
  assign event_valid = event_valid_reg;

endmodule

/* File: hw/mpm_persist.v */
/*
 * Persistence timer: counts time ticks while a condition holds and
 * reports expiry once the count passes the programmed limit.
 * Assumes a one-cycle tick pulse from the monitor's prescaler.
 */
`timescale 1ns/10ps

module mpm_persist #(
  parameter CW = 16
) (
  input wire clk,
  input wire resetn,
  input wire tick,
  input wire cond,
  input wire [CW-1:0] limit,
  output wire expired
);

  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] cnt_next;

  // ----------------------------------------------------------------------
  // tick counter, saturating so a long fault never wraps back to clear
  // ----------------------------------------------------------------------
  always @* begin
    cnt_next = cnt_reg;
    if (!cond) begin
      cnt_next = {CW{1'b0}};
    end else if (tick && cnt_reg != {CW{1'b1}}) begin
      cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= {CW{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // strictly longer than the limit, not equal to it
  assign expired = cond && (cnt_reg > limit);

endmodule

/* File: verif/mpm_checker.sv */
/* checker for the fault monitor: event, fault, irq and bus relations.
   assumes binding to mpm_monitor with the same tick prescale. */
`timescale 1ns/10ps
`include "mpm_defs.vh"
module mpm_checker #(parameter TICK_CYCLES = 4, parameter DW = 16) (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire pslverr,
  input wire [DW-1:0] line_freq_reading,
  input wire motor_running,
  input wire accessory_bay_first_present,
  input wire accessory_bay_first_compat,
  input wire accessory_bay_second_present,
  input wire accessory_bay_second_compat,
  input wire irq,
  input wire fault_out,
  input wire [7:0] event_code,
  input wire event_valid
);
  localparam int FLIM = 500 * TICK_CYCLES;
  localparam int FHI = 2 * TICK_CYCLES + 4;
  logic [15:0] fcnt;
  // both bands overlap, so only the outer edges matter
  wire fout = motor_running && (line_freq_reading < `MPM_F50_LO ||
    line_freq_reading > `MPM_F60_HI);
  // cycles of unbroken out-of-band running
  always @(posedge clk or negedge resetn) begin
    if (!resetn) fcnt <= 16'h0000;
    else if (!fout) fcnt <= 16'h0000;
    else if (fcnt != 16'hFFFF) fcnt <= fcnt + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // error only in the access phase, only for unmapped or unaligned words
  slverr_access_a: assert property (pslverr == (psel && penable &&
    (paddr > `MPM_OFS_LAST_EVENT || paddr[1:0] != 2'b00)))
    else $error("slave error does not match address");
  code_change_a: assert property (
    !$stable(event_code) |-> event_valid)
    else $error("event code moved without a pulse");
  code_range_a: assert property (
    event_valid |-> event_code inside {[8'h4A:8'h53]})
    else $error("event code out of range");
  bay_first_a: assert property (
    $rose(accessory_bay_first_present && !accessory_bay_first_compat)
    |-> ##[1:3] event_valid)
    else $error("first bay fault missing");
  bay_second_a: assert property (
    $rose(accessory_bay_second_present && !accessory_bay_second_compat)
    |-> ##[1:3] event_valid)
    else $error("second bay fault missing");
  fault_rise_a: assert property (
    $rose(fault_out) |-> event_valid || $past(psel && penable && pwrite))
    else $error("fault rose without cause");
  irq_rise_a: assert property ($rose(irq) |-> event_valid ||
    $past(psel && penable && pwrite))
    else $error("irq rose without cause");
  freq_fault_a: assert property (
    fcnt == FLIM |-> ##[1:FHI] event_valid)
    else $error("frequency fault late");
endmodule
bind mpm_monitor mpm_checker #(.TICK_CYCLES(TICK_CYCLES), .DW(DW))
  mpm_checker_inst (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pslverr, .line_freq_reading, .motor_running,
  .accessory_bay_first_present,
  .accessory_bay_first_compat, .accessory_bay_second_present,
  .accessory_bay_second_compat, .irq, .fault_out, .event_code,
  .event_valid);

/* File: verif/testbench.sv */
/* self-checking bench for the fault monitor: apb tasks and scenarios.
   assumes a tick prescale of four clocks to keep timers short. */
`timescale 1ns/10ps
module testbench;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
  logic [7:0] paddr = 8'h00, event_code;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] ia = 16'h0064, ib = 16'h0064, ic = 16'h0064;
  logic [15:0] fq = 16'h01F4, tq = 16'h0064, pw = 16'h0064;
  logic [15:0] tv [4] = '{16'h003C, 16'h0082, 16'h0064, 16'h0064};
  logic [15:0] pv [4] = '{16'h0064, 16'h0064, 16'h0046, 16'h0082};
  logic run = 0, ramp = 0, opn = 0, fb = 0, p1 = 0, c1 = 1, p2 = 0, c2 = 1;
  logic pslverr, err, irq, fault_out, alarm_out, event_valid;
  int fails = 0, tests_run = 0;
  mpm_monitor #(.TICK_CYCLES(4)) mpm_monitor_inst (.clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .phase_a_current_reading(ia), .phase_b_current_reading(ib),
    .phase_c_current_reading(ic), .line_freq_reading(fq),
    .motor_torque_reading(tq), .motor_power_reading(pw),
    .motor_running(run), .ramp_end(ramp), .bypass_open_cmd(opn),
    .bypass_closed_fb(fb), .accessory_bay_first_present(p1),
    .accessory_bay_first_compat(c1), .accessory_bay_second_present(p2),
    .accessory_bay_second_compat(c2), .irq, .fault_out, .alarm_out,
    .event_code, .event_valid);
  // 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // sample on the falling edge so registered outputs have settled
  task automatic wev(input logic [7:0] code, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (event_valid !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({23'h0, event_valid, event_code}, {23'h0, 1'b1, code});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    fails++;
    results();
  end
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h000A0014);
    apb(1'b0, 8'h3C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test regs done");
    apb(1'b1, 8'h14, 32'h0002000A);
    ia <= 16'h0078;
    repeat (6) @(posedge clk);
    ia <= 16'h0064;
    repeat (2) @(posedge clk);
    ia <= 16'h0078;
    repeat (8) @(negedge clk);
    chk({31'h0, fault_out}, 32'h0);
    wev(8'h4A, 20);
    chk({30'h0, fault_out, irq}, 32'h2);
    apb(1'b1, 8'h30, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h0000004A);
    ia <= 16'h0064;
    apb(1'b1, 8'h2C, 32'h3FF);
    @(negedge clk);
    chk({30'h0, fault_out, irq}, 32'h0);
    $display("test imbalance done");
    // bit 3 is asked for as an alarm too, but may only ever be a fault
    apb(1'b1, 8'h04, 32'h18);
    for (int i = 0; i < 4; i++) begin
      tq <= tv[i];
      pw <= pv[i];
      wev(8'h4E + i[7:0], 60);
      chk({31'h0, alarm_out}, {31'h0, i == 0});
      @(posedge clk);
      tq <= 16'h0064;
      pw <= 16'h0064;
      @(posedge clk);
    end
    run <= 1'b1;
    fq <= 16'h02BC;
    wev(8'h4B, 2100);
    @(posedge clk);
    fq <= 16'h01F4;
    $display("test limits done");
    ia <= 16'h0005;
    ib <= 16'h0005;
    ic <= 16'h0005;
    ramp <= 1'b1;
    @(posedge clk);
    ramp <= 1'b0;
    wev(8'h4C, 5);
    apb(1'b1, 8'h2C, 32'h3FF);
    apb(1'b1, 8'h00, 32'h0);
    ramp <= 1'b1;
    @(posedge clk);
    ramp <= 1'b0;
    repeat (3) @(negedge clk);
    chk({31'h0, fault_out}, 32'h0);
    // live bit was set by the last check; a skipped check must drop it
    apb(1'b0, 8'h34, 32'h0);
    chk({31'h0, rd[2]}, 32'h0);
    @(posedge clk);
    fb <= 1'b1;
    opn <= 1'b1;
    @(posedge clk);
    opn <= 1'b0;
    wev(8'h4D, 500);
    chk({31'h0, fault_out}, 32'h1);
    $display("test bypass done");
    @(posedge clk);
    p1 <= 1'b1;
    c1 <= 1'b0;
    wev(8'h52, 5);
    @(posedge clk);
    p2 <= 1'b1;
    c2 <= 1'b0;
    wev(8'h53, 5);
    $display("test bays done");
    results();
  end
endmodule
